// ===== pkg/baud_clk_pkg.sv
// Package: register map, field layout, reset values and types of the baud clock block
package baud_clk_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [3:0] SYS_CTRL_OFS   = 4'h0;
  localparam logic [3:0] BAUD_CTRL_OFS  = 4'h4;
  localparam logic [3:0] BAUD_FRAC_OFS  = 4'h8;
  localparam logic [3:0] MODE_CTRL_OFS  = 4'hC;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  // system_clock_control
  localparam int PRESCALE_SRC_LSB = 0;   // [1:0]
  localparam int PERIPH_SEL_BIT   = 2;
  localparam int GEAR_LSB         = 4;   // [5:4]
  // baud_control_reg
  localparam int DIVISOR_LSB      = 0;   // [3:0]
  localparam int TAP_SEL_LSB      = 4;   // [5:4]
  localparam int FRAC_EN_BIT      = 6;
  // baud_fraction_reg
  localparam int FRAC_LSB         = 0;   // [3:0]
  // mode control
  localparam int UART_MODE_BIT    = 0;
  localparam int CLK_SRC_LSB      = 1;   // [2:1]
  // Status bits in mode control read word
  localparam int STAT_PRESC_RUN   = 8;
  localparam int STAT_SER_CLK     = 9;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] SYS_CTRL_RST   = 5'h00;
  localparam logic [6:0] BAUD_CTRL_RST  = 7'h00;
  localparam logic [3:0] BAUD_FRAC_RST  = 4'h0;
  localparam logic [2:0] MODE_CTRL_RST  = 3'h1;

  // ----------------------------------------------------------------------
  // Divider constants
  // ----------------------------------------------------------------------
  localparam logic [4:0] DIV_FULL       = 5'h10;  // Divisor field 0 means 16
  localparam logic [4:0] FRAC_BASE      = 5'h10;  // Fraction step is 16 - K
  localparam logic [3:0] OVERSAMPLE_MAX = 4'hF;   // 16x UART oversampling

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PRESC_DIV16 = 2'b00,
    PRESC_DIV8  = 2'b01,
    PRESC_DIV4  = 2'b10,
    PRESC_RSVD  = 2'b11
  } presc_src_e;

  typedef enum logic [1:0] {
    SRC_BAUD_GEN = 2'b00,
    SRC_SYS_HALF = 2'b01,
    SRC_TIMER    = 2'b10,
    SRC_EXT      = 2'b11
  } clk_src_e;

  typedef struct packed {
    logic [1:0] gear;
    logic       periph_clock_sel;
    logic [1:0] prescale_source_sel;
  } sys_ctrl_s;

  typedef struct packed {
    logic       fraction_enable;
    logic [1:0] baud_input_tap_sel;
    logic [3:0] baud_integer_divisor;
    logic [3:0] baud_fraction_value;
  } baud_cfg_s;

endpackage

// ===== hw/tap_prescaler.sv
// Prescaler: base clock enable and four tap enables
`timescale 1ns/10ps
module tap_prescaler (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       gear_tick_i,
  input  wire baud_clk_pkg::sys_ctrl_s    ctrl_i,
  input  wire logic                       run_i,
  output logic [3:0]                      tap_o
);

  // ----------------------------------------------------------------------
  // Peripheral clock and base tap
  // ----------------------------------------------------------------------
  logic       periph_tick;
  logic [3:0] pre_cnt_r;
  logic       base_tick;
  logic [5:0] presc_r;

  // Geared tick when select is 0, raw clock when 1 (see RL3)
  assign periph_tick = ctrl_i.periph_clock_sel ? 1'b1 : gear_tick_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_r <= 4'h0;
    end else if (ce_i && run_i && periph_tick) begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
    end
  end

  // Base tap is fperiph/16, /8 or /4 (see RL2)
  always_comb begin
    case (baud_clk_pkg::presc_src_e'(ctrl_i.prescale_source_sel))
      baud_clk_pkg::PRESC_DIV16: base_tick = periph_tick && &pre_cnt_r;
      baud_clk_pkg::PRESC_DIV8:  base_tick = periph_tick && &pre_cnt_r[2:0];
      baud_clk_pkg::PRESC_DIV4:  base_tick = periph_tick && &pre_cnt_r[1:0];
      default:                   base_tick = periph_tick && &pre_cnt_r;
    endcase
  end

  // ----------------------------------------------------------------------
  // 6-bit prescaler and output taps
  // ----------------------------------------------------------------------
  // Held in reset while idle, so enabling it restarts phase cleanly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_r <= 6'h00;
    end else if (ce_i) begin
      if (!run_i) begin
        presc_r <= 6'h00;                        // see RL4
      end else if (base_tick) begin
        presc_r <= presc_r + 6'h01;              // see RL1
      end
    end
  end

  // Taps divide the base by 1, 4, 16 and 64 (see RL5)
  assign tap_o[0] = run_i && base_tick;
  assign tap_o[1] = run_i && base_tick && &presc_r[1:0];
  assign tap_o[2] = run_i && base_tick && &presc_r[3:0];
  assign tap_o[3] = run_i && base_tick && &presc_r[5:0];

endmodule

// ===== hw/frac_divider.sv
// Baud rate divider: integer N or N + (16 - K)/16
`timescale 1ns/10ps
module frac_divider (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       in_tick_i,
  input  wire baud_clk_pkg::baud_cfg_s    cfg_i,
  output logic                            out_tick_o
);

  // ----------------------------------------------------------------------
  // Divider counter and phase accumulator
  // ----------------------------------------------------------------------
  logic [4:0] cnt_r;
  logic [3:0] phase_r;
  logic [4:0] divisor;
  logic [4:0] phase_sum;
  logic       stretch;
  logic [4:0] limit;

  // Field 0 means sixteen (see RL19)
  assign divisor = (cfg_i.baud_integer_divisor == 4'h0) ?
                   baud_clk_pkg::DIV_FULL : {1'b0, cfg_i.baud_integer_divisor};

  // Fraction ignored when disabled (see RL11); step 16 - K (see RL20)
  assign phase_sum = {1'b0, phase_r}
                   + (baud_clk_pkg::FRAC_BASE
                      - {1'b0, cfg_i.baud_fraction_value});
  assign stretch   = cfg_i.fraction_enable && phase_sum[4];   // see RL12
  assign limit     = stretch ? divisor : divisor - 5'h01;
  assign out_tick_o = in_tick_i && (cnt_r >= limit);          // see RL10

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
    end else if (ce_i && in_tick_i) begin
      cnt_r <= (cnt_r >= limit) ? 5'h00 : cnt_r + 5'h01;
    end
  end

  // Carry out of the accumulator adds one input period (see RL20)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= 4'h0;
    end else if (ce_i) begin
      if (!cfg_i.fraction_enable) begin
        phase_r <= 4'h0;
      end else if (out_tick_o) begin
        phase_r <= phase_sum[3:0];
      end
    end
  end

endmodule

// ===== hw/baud_clock_gen.sv
// Serial baud clock generator with classic Wishbone register slave
//
// Behaviour
// RL1 - A 6-bit prescaler divides the chosen peripheral clock.
// RL2 - Source select 00, 01, 10 gives peripheral clock /16, /8, /4.
// RL3 - Peripheral select 0 uses geared clock, 1 uses the raw clock.
// RL4 - Prescaler runs only when baud generator is the serial source.
// RL5 - Prescaler taps divide its base by 1, 4, 16 and 64.
// RL6 - Software keeps every used tap below half the system clock.
// RL7 - Software leaves the gear alone while the channel is active.
// RL8 - Software avoids prohibited fast tap combinations with raw clock.
// RL9 - Two-bit tap select routes one tap into the baud generator.
// RL10 - Generator divides by 1, by N plus fraction, or by 16.
// RL11 - Fraction off: fraction ignored, divide by integer N 1 to 16.
// RL12 - Fraction on: divide by N + (16 - K)/16.
// RL13 - Software clears fraction enable when N is 1 or 16.
// RL14 - Synchronous mode uses no fraction; integer N only.
// RL15 - UART mode: generator output is a 16x oversampling clock.
// RL16 - UART mode may bypass the generator with half system clock.
// RL17 - Synchronous mode halves the generator output for shift clock.
// RL18 - Unbuffered synchronous mode needs divisor 2 or more on fastest tap.
// RL19 - Divisor field 0 means sixteen; 1 to 15 are themselves.
// RL20 - Fraction made by stretching periods via 4-bit phase accumulator.
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
module baud_clock_gen (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        gear_tick_i,
  input  wire logic        timer_tick_i,
  input  wire logic        ext_tick_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  output logic             ser_tick_o,
  output logic             bit_tick_o
);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  baud_clk_pkg::sys_ctrl_s sys_r;
  logic [6:0]              baud_ctrl_r;
  logic [3:0]              baud_frac_r;
  logic                    uart_mode_r;
  logic [1:0]              clk_src_r;
  baud_clk_pkg::baud_cfg_s cfg;

  // ----------------------------------------------------------------------
  // Datapath signals
  // ----------------------------------------------------------------------
  logic       presc_run;
  logic [3:0] taps;
  logic       gen_in;
  logic       gen_out;
  logic       sys_half_r;
  logic       shift_half_r;
  logic [3:0] over_r;
  logic       src_tick;
  logic       ser_nxt;
  logic       bit_nxt;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        hit;
  logic [31:0] rd_nxt;

  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign wr  = req && we_i && sel_i[0];
  assign hit = (adr_i == baud_clk_pkg::SYS_CTRL_OFS)
            || (adr_i == baud_clk_pkg::BAUD_CTRL_OFS)
            || (adr_i == baud_clk_pkg::BAUD_FRAC_OFS)
            || (adr_i == baud_clk_pkg::MODE_CTRL_OFS);

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (adr_i)
      baud_clk_pkg::SYS_CTRL_OFS: begin
        rd_nxt[baud_clk_pkg::PRESCALE_SRC_LSB +: 2] = sys_r.prescale_source_sel;
        rd_nxt[baud_clk_pkg::PERIPH_SEL_BIT]        = sys_r.periph_clock_sel;
        rd_nxt[baud_clk_pkg::GEAR_LSB +: 2]         = sys_r.gear;
      end
      baud_clk_pkg::BAUD_CTRL_OFS: rd_nxt[6:0] = baud_ctrl_r;
      baud_clk_pkg::BAUD_FRAC_OFS: rd_nxt[3:0] = baud_frac_r;
      baud_clk_pkg::MODE_CTRL_OFS: begin
        rd_nxt[baud_clk_pkg::UART_MODE_BIT]    = uart_mode_r;
        rd_nxt[baud_clk_pkg::CLK_SRC_LSB +: 2] = clk_src_r;
        rd_nxt[baud_clk_pkg::STAT_PRESC_RUN]   = presc_run;
        rd_nxt[baud_clk_pkg::STAT_SER_CLK]     = ser_tick_o;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // One-cycle answer; unmapped addresses get err instead of ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= req && hit;
      err_o <= req && !hit;
      dat_o <= (req && hit && !we_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Writes take effect at the edge ending the request cycle, the same edge that raises ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_r       <= baud_clk_pkg::SYS_CTRL_RST;
      baud_ctrl_r <= baud_clk_pkg::BAUD_CTRL_RST;
      baud_frac_r <= baud_clk_pkg::BAUD_FRAC_RST;
      uart_mode_r <= baud_clk_pkg::MODE_CTRL_RST[0];
      clk_src_r   <= baud_clk_pkg::MODE_CTRL_RST[2:1];
    end else if (ce_i && wr) begin
      case (adr_i)
        baud_clk_pkg::SYS_CTRL_OFS: begin
          sys_r.prescale_source_sel <=
            dat_i[baud_clk_pkg::PRESCALE_SRC_LSB +: 2];
          sys_r.periph_clock_sel <= dat_i[baud_clk_pkg::PERIPH_SEL_BIT];
          sys_r.gear             <= dat_i[baud_clk_pkg::GEAR_LSB +: 2];
        end
        baud_clk_pkg::BAUD_CTRL_OFS: baud_ctrl_r <= dat_i[6:0];
        baud_clk_pkg::BAUD_FRAC_OFS: baud_frac_r <= dat_i[3:0];
        baud_clk_pkg::MODE_CTRL_OFS: begin
          uart_mode_r <= dat_i[baud_clk_pkg::UART_MODE_BIT];
          clk_src_r   <= dat_i[baud_clk_pkg::CLK_SRC_LSB +: 2];
        end
        default: uart_mode_r <= uart_mode_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler and baud generator
  // ----------------------------------------------------------------------
  // Synchronous mode always uses the generator; only UART picks a source
  assign presc_run = !uart_mode_r
                  || (clk_src_r == baud_clk_pkg::SRC_BAUD_GEN);  // see RL4

  // Synchronous mode forces fraction off regardless of the bit (see RL14)
  assign cfg.fraction_enable =
    baud_ctrl_r[baud_clk_pkg::FRAC_EN_BIT] && uart_mode_r;
  assign cfg.baud_input_tap_sel   = baud_ctrl_r[baud_clk_pkg::TAP_SEL_LSB +: 2];
  assign cfg.baud_integer_divisor = baud_ctrl_r[baud_clk_pkg::DIVISOR_LSB +: 4];
  assign cfg.baud_fraction_value  = baud_frac_r[baud_clk_pkg::FRAC_LSB +: 4];

  tap_prescaler u_presc (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .gear_tick_i (gear_tick_i),
    .ctrl_i      (sys_r),
    .run_i       (presc_run),
    .tap_o       (taps)
  );

  assign gen_in = taps[cfg.baud_input_tap_sel];                // see RL9

  frac_divider u_div (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .in_tick_i  (gen_in),
    .cfg_i      (cfg),
    .out_tick_o (gen_out)
  );

  // ----------------------------------------------------------------------
  // Serial clock selection and bit rate
  // ----------------------------------------------------------------------
  // Half system clock toggles freely for the bypass path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_half_r <= 1'b0;
    end else if (ce_i) begin
      sys_half_r <= !sys_half_r;
    end
  end

  // Timer and external ticks are assumed already synchronous single pulses
  always_comb begin
    case (baud_clk_pkg::clk_src_e'(clk_src_r))
      baud_clk_pkg::SRC_BAUD_GEN: src_tick = gen_out;
      baud_clk_pkg::SRC_SYS_HALF: src_tick = sys_half_r;      // see RL16
      baud_clk_pkg::SRC_TIMER:    src_tick = timer_tick_i;
      baud_clk_pkg::SRC_EXT:      src_tick = ext_tick_i;
      default:                    src_tick = gen_out;
    endcase
  end

  // UART: every 16th serial tick ends a bit; sync: every 2nd generator tick
  always_comb begin
    if (uart_mode_r) begin
      ser_nxt = src_tick;
      bit_nxt = src_tick
             && (over_r == baud_clk_pkg::OVERSAMPLE_MAX);     // see RL15
    end else begin
      ser_nxt = gen_out && shift_half_r;                       // see RL17
      bit_nxt = gen_out && shift_half_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      over_r <= 4'h0;
    end else if (ce_i && uart_mode_r && src_tick) begin
      over_r <= over_r + 4'h1;                                 // see RL15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_half_r <= 1'b0;
    end else if (ce_i && !uart_mode_r && gen_out) begin
      shift_half_r <= !shift_half_r;                           // see RL17
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else if (ce_i) begin
      ser_tick_o <= ser_nxt;
      bit_tick_o <= bit_nxt;
    end
  end

endmodule

// ===== verif/baud_clock_gen_assertions.sv
// Concurrent checks on the baud clock generator ports
`timescale 1ns/10ps
module baud_clock_gen_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        timer_tick_i,
  input wire logic        ext_tick_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        ser_tick_o,
  input wire logic        bit_tick_o
);
  logic [2:0] mode_r;
  logic [3:0] settle_r;
  logic       req;
  logic       quiet;
  logic       mode_wr;
  logic       uart;
  logic [1:0] src;
  assign req   = cyc_i && stb_i && ce_i && !ack_o && !err_o;
  // A source switch lands at the acknowledge edge, so that edge is noisy too
  assign mode_wr = ack_o && we_i && sel_i[0]
                && adr_i == baud_clk_pkg::MODE_CTRL_OFS;
  assign quiet   = settle_r == 4'hF && !mode_wr;
  assign uart  = mode_r[baud_clk_pkg::UART_MODE_BIT];
  assign src   = mode_r[2:1];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------------
  // Mode seen on the bus; a change may give one odd period, so wait
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r   <= baud_clk_pkg::MODE_CTRL_RST;
      settle_r <= 4'h0;
    end else if (mode_wr) begin
      mode_r   <= dat_i[2:0];
      settle_r <= 4'h0;
    end else if (!quiet) begin
      settle_r <= settle_r + 4'h1;
    end
  end
  property p_ack_take;
    req && adr_i[1:0] == 2'b00 |=> ack_o && !err_o;
  endproperty
  a_ack_take: assert property (p_ack_take)
    else $error("mapped access not acknowledged");
  property p_err_unmapped;
    req && adr_i[1:0] != 2'b00 |=> err_o && !ack_o;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access not refused");
  property p_ack_pulse;
    ack_o && ce_i |=> !ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");
  property p_dat_idle;
    !ack_o |-> dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside acknowledge");
  property p_ser_pulse;
    quiet && ser_tick_o && ce_i |=> !ser_tick_o;
  endproperty
  a_ser_pulse: assert property (p_ser_pulse)
    else $error("serial tick longer than one cycle");
  property p_half_sys;
    quiet && uart && src == 2'b01 && $past(ce_i)
      |-> ser_tick_o != $past(ser_tick_o);
  endproperty
  a_half_sys: assert property (p_half_sys)
    else $error("bypass tick not every other cycle");
  property p_sync_bit;
    quiet && !uart |-> bit_tick_o == ser_tick_o;
  endproperty
  a_sync_bit: assert property (p_sync_bit)
    else $error("shift bit tick differs from serial tick");
  property p_presc_idle;
    ack_o && !we_i && adr_i == baud_clk_pkg::MODE_CTRL_OFS && uart
      && src != 2'b00 |-> !dat_o[baud_clk_pkg::STAT_PRESC_RUN];
  endproperty
  a_presc_idle: assert property (p_presc_idle)
    else $error("prescaler running with other source");
  property p_ext_follow;
    quiet && uart && src[1] && (src[0] ? ext_tick_i : timer_tick_i)
      |=> ser_tick_o;
  endproperty
  a_ext_follow: assert property (p_ext_follow)
    else $error("outside tick not passed on");
endmodule
bind baud_clock_gen baud_clock_gen_chk baud_clock_gen_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .timer_tick_i(timer_tick_i),
  .ext_tick_i(ext_tick_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .err_o(err_o), .ser_tick_o(ser_tick_o),
  .bit_tick_o(bit_tick_o));

// ===== verif/test_baud_clock_gen.sv
// Self-checking bench for the serial baud clock generator
`timescale 1ns/10ps
module test_baud_clock_gen;
  localparam logic [3:0] SYS  = baud_clk_pkg::SYS_CTRL_OFS;
  localparam logic [3:0] BAUD = baud_clk_pkg::BAUD_CTRL_OFS;
  localparam logic [3:0] FRAC = baud_clk_pkg::BAUD_FRAC_OFS;
  localparam logic [3:0] MODE = baud_clk_pkg::MODE_CTRL_OFS;
  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic        ce_i         = 1'b1;
  logic        gear_tick_i  = 1'b0;
  logic        timer_tick_i = 1'b0;
  logic        ext_tick_i   = 1'b0;
  logic        cyc_i        = 1'b0;
  logic        stb_i        = 1'b0;
  logic        we_i         = 1'b0;
  logic [3:0]  adr_i        = 4'h0;
  logic [3:0]  sel_i        = 4'h0;
  logic [31:0] dat_i        = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  logic        ser_tick_o;
  logic        bit_tick_o;
  int          cnt          = 0;
  int          miscompares  = 0;
  int          tests_run    = 0;
  baud_clock_gen baud_clock_gen_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .gear_tick_i(gear_tick_i),
    .timer_tick_i(timer_tick_i), .ext_tick_i(ext_tick_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .ser_tick_o(ser_tick_o), .bit_tick_o(bit_tick_o));
  always #12.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------------
  // Gear, timer and outside ticks at fixed rates of 2, 10 and 6 cycles
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    cnt          <= cnt + 1;
    gear_tick_i  <= cnt % 2 == 0;
    timer_tick_i <= cnt % 10 == 0;
    ext_tick_i   <= cnt % 6 == 0;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q,
                    output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1 && err_o !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    wb(a, 1'b1, d, 4'hF, q, e);
  endtask
  function automatic logic hit(input logic b);
    return b ? bit_tick_o : ser_tick_o;
  endfunction
  // Cycles from one pulse to the next; the wait is bounded
  task automatic gap(input logic b, output int g);
    int n;
    n = 0;
    g = 0;
    while (hit(b) !== 1'b1 && n < 9000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    do begin
      @(posedge clk_i);
      #1;
      g++;
    end while (hit(b) !== 1'b1 && g < 9000);
    if (g >= 9000) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // First period after a change may be odd, so it is skipped
  task automatic per(input logic [7:0] sy, input logic [7:0] bc,
                     input logic [7:0] k, input logic [7:0] md,
                     input logic b, input int exp);
    int g;
    wr(SYS, {24'h0, sy});
    wr(BAUD, {24'h0, bc});
    wr(FRAC, {24'h0, k});
    wr(MODE, {24'h0, md});
    gap(b, g);
    gap(b, g);
    check(g, exp);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    wb(SYS, 1'b0, 32'h0, 4'hF, q, e);
    check(q, 32'h0);
    wb(BAUD, 1'b0, 32'h0, 4'hF, q, e);
    check(q, 32'h0);
    wb(MODE, 1'b0, 32'h0, 4'hF, q, e);
    check(32'(q[8:0]), 32'h101);
    wb(4'h2, 1'b0, 32'h0, 4'hF, q, e);
    check(32'(e), 32'h1);
    wb(BAUD, 1'b1, 32'h7F, 4'h0, q, e);
    wb(BAUD, 1'b0, 32'h0, 4'hF, q, e);
    check(q, 32'h0);
    wr(BAUD, 32'h7F);
    wb(BAUD, 1'b0, 32'h0, 4'hF, q, e);
    check(q, 32'h7F);
    wr(MODE, 32'h305);
    wb(MODE, 1'b0, 32'h0, 4'hF, q, e);
    check(32'(q[8:0]), 32'h005);
  endtask
  // Raw clock and /4 keep every tap below half the system clock
  task automatic t_div();
    for (int i = 0; i < 3; i++) begin
      per(8'h04 | 8'(i), 8'h01, 8'h0, 8'h01, 1'b0, 16 >> i);
    end
    for (int t = 0; t < 4; t++) begin
      per(8'h06, {2'b00, 2'(t), 4'h1}, 8'h0, 8'h01, 1'b0,
          4 << (2 * t));
    end
    // Fraction off for every N, also 1 and 16
    for (int n = 0; n < 16; n++) begin
      per(8'h06, 8'(n), 8'(n), 8'h01, 1'b0,
          4 * (n == 0 ? 16 : n));
    end
    // Gear setting left alone and no prohibited pair
    per(8'h02, 8'h01, 8'h0, 8'h01, 1'b0, 8);
  endtask
  task automatic t_frac();
    int g;
    int sum;
    sum = 0;
    wr(SYS, 32'h06);
    wr(BAUD, 32'h44);
    wr(FRAC, 32'hE);
    wr(MODE, 32'h01);
    gap(1'b0, g);
    for (int i = 0; i < 16; i++) begin
      gap(1'b0, g);
      sum += g;
    end
    check(sum, 264);
  endtask
  // Clock enable low must freeze the toggling bypass tick, then release it
  task automatic t_hold();
    logic s;
    int   n;
    n = 0;
    @(posedge clk_i);
    ce_i <= 1'b0;
    @(posedge clk_i);
    #1;
    s = ser_tick_o;
    repeat (20) begin
      @(posedge clk_i);
      #1;
      n += (ser_tick_o !== s) ? 1 : 0;
    end
    @(posedge clk_i);
    ce_i <= 1'b1;
    check(n, 0);
    gap(1'b0, n);
    gap(1'b0, n);
    check(n, 2);
  endtask
  // Shift mode uses N of 4, so two or more
  task automatic t_modes();
    per(8'h06, 8'h01, 8'h0, 8'h01, 1'b1, 64);
    per(8'h06, 8'h44, 8'h1, 8'h00, 1'b0, 32);
    per(8'h06, 8'h44, 8'h1, 8'h00, 1'b1, 32);
    per(8'h06, 8'h01, 8'h0, 8'h03, 1'b0, 2);
    t_hold();
    per(8'h06, 8'h01, 8'h0, 8'h05, 1'b0, 10);
    per(8'h06, 8'h01, 8'h0, 8'h07, 1'b0, 6);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_div();
    t_frac();
    t_modes();
    end_of_test();
  end
endmodule
